// ---- rtl/usb_ep_pkg.sv ----
package usb_ep_pkg;

  // ==========================================================================
  // endpoint map
  localparam int NUM_PHYS = 32;
  localparam int NUM_LOG = 16;
  localparam int EP_W = 5;
  localparam int LEN_W = 10;
  localparam int CNT_W = 11;

  // ==========================================================================
  // packet memory, one 32-bit word per entry
  localparam int RAM_AW = 11;
  localparam int RAM_WORDS = 2048;
  localparam int ALLOC_W = 15;
  localparam int HDR_OFS = 0;
  localparam int DATA_OFS = 1;

  // ==========================================================================
  // timing at the system clock
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int FRAME_TIME_MS = 1;
  localparam int FRAME_CYCLES = CLK_FREQ_HZ / 1000 * FRAME_TIME_MS;
  localparam int FS_BIT_RATE_BPS = 12_000_000;

  // ==========================================================================
  // legal packet size limits
  localparam logic [9:0] MPS_MIN = 10'h001;
  localparam logic [9:0] MPS_SMALL_MAX = 10'h040;
  localparam logic [9:0] MPS_CB_DEFAULT = 10'h008;

  typedef enum logic [1:0]
  {
    EP_CTRL = 2'b00,
    EP_INTR = 2'b01,
    EP_BULK = 2'b10,
    EP_ISO = 2'b11
  } ep_type_t;

  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_RX = 3'b001,
    S_RX_HDR = 3'b010,
    S_TX_FETCH = 3'b011,
    S_TX_LOAD = 3'b100,
    S_TX_SEND = 3'b101,
    S_TX_ACK = 3'b110
  } sie_state_t;

  // fixed type of each logical endpoint number
  function automatic ep_type_t type_of(input logic [3:0] n);
    ep_type_t t;
    t = EP_BULK;
    if (n == 4'h0)
      t = EP_CTRL;
    else if (n == 4'h1 || n == 4'h4 || n == 4'h7 || n == 4'hA || n == 4'hD)
      t = EP_INTR;
    else if (n == 4'h3 || n == 4'h6 || n == 4'h9 || n == 4'hC)
      t = EP_ISO;
    return t;
  endfunction

  // force a programmed packet size into the legal set of its type
  function automatic logic [9:0] mps_legal(input ep_type_t t, input logic [9:0] raw);
    logic [9:0] m;
    m = raw;
    unique case (t)
      EP_CTRL, EP_BULK:
        if (raw != 10'h008 && raw != 10'h010 && raw != 10'h020 && raw != 10'h040)
          m = MPS_CB_DEFAULT;
      EP_INTR:
        if (raw == 10'h000)
          m = MPS_MIN;
        else if (raw > MPS_SMALL_MAX)
          m = MPS_SMALL_MAX;
      EP_ISO:
        if (raw == 10'h000)
          m = MPS_MIN;
    endcase
    return m;
  endfunction

endpackage

// ---- rtl/usb_ep_ram.sv ----
`timescale 1ns/1ps

// ============================================================================
// two-port packet memory: port a faces the serial engine, port b the processor
module usb_ep_ram
(
  // clock
  input wire logic clk_sys,
  // port a
  input wire logic a_we,
  input wire logic a_re,
  input wire logic [usb_ep_pkg::RAM_AW-1:0] a_addr,
  input wire logic [31:0] a_wdata,
  output logic [31:0] a_q,
  // port b
  input wire logic b_we,
  input wire logic b_re,
  input wire logic [usb_ep_pkg::RAM_AW-1:0] b_addr,
  input wire logic [31:0] b_wdata,
  output logic [31:0] b_q
);

  logic [31:0] mem [usb_ep_pkg::RAM_WORDS];

  // port a; read data holds until the next read so it can feed a port directly
  always_ff @(posedge clk_sys)
  begin
    if (a_we)
      mem[a_addr] <= a_wdata;
    if (a_re)
      a_q <= mem[a_addr];
  end

  // port b; the two ports address the same buffer at once only when an isochronous OUT packet overwrites a full one
  always_ff @(posedge clk_sys)
  begin
    if (b_we)
      mem[b_addr] <= b_wdata;
    if (b_re)
      b_q <= mem[b_addr];
  end

endmodule

// ---- rtl/usb_fs_endpoint_dataflow.sv ----
`timescale 1ns/1ps

module usb_fs_endpoint_dataflow
#(
  parameter int FRAME_CYCLES = usb_ep_pkg::FRAME_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // endpoint configuration
  input wire logic [usb_ep_pkg::NUM_PHYS-1:0] ep_realized,
  input wire logic [usb_ep_pkg::NUM_PHYS*usb_ep_pkg::LEN_W-1:0] ep_mps,
  input wire logic [2:0] nak_int_out_en,
  input wire logic [2:0] nak_int_in_en,
  // token and receive stream from the serial interface engine
  input wire logic tok_valid,
  input wire logic tok_in,
  input wire logic [3:0] tok_ep,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_pkt_end,
  input wire logic rx_pkt_err,
  // transmit stream and handshakes to the serial interface engine
  input wire logic tx_ready,
  input wire logic tx_ack,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  output logic tx_zlp,
  output logic hs_ack,
  output logic hs_nak,
  // processor transfer port
  input wire logic [usb_ep_pkg::EP_W-1:0] cpu_ep,
  input wire logic rx_len_rd,
  input wire logic rx_data_rd,
  output logic [31:0] cpu_rdata,
  input wire logic tx_len_wr,
  input wire logic [usb_ep_pkg::LEN_W-1:0] tx_len,
  input wire logic tx_data_wr,
  input wire logic [31:0] tx_data,
  input wire logic tx_iso_validate,
  // events and status
  input wire logic [usb_ep_pkg::NUM_PHYS-1:0] ep_int_clr,
  output logic [usb_ep_pkg::NUM_PHYS-1:0] ep_int,
  output logic frame_int,
  output logic [2*usb_ep_pkg::NUM_PHYS-1:0] buf_full,
  output logic alloc_err
);

  localparam int NP = usb_ep_pkg::NUM_PHYS;
  localparam int AW = usb_ep_pkg::RAM_AW;
  localparam int FW = $clog2(FRAME_CYCLES + 1);

  // ==========================================================================
  // buffer allocation
  logic [9:0] mps_e [NP];
  logic [usb_ep_pkg::ALLOC_W-1:0] buf_words [NP];
  logic [usb_ep_pkg::ALLOC_W-1:0] ep_base [NP+1];
  logic [NP-1:0] dbl;
  logic [NP-1:0] ep_live;
  logic [NP-1:0] is_iso;

  assign ep_base[0] = '0;

  // allocation is a running sum, so endpoints left unrealized take no space
  generate
    for (genvar i = 0; i < NP; i++)
    begin : g_alloc
      localparam usb_ep_pkg::ep_type_t T = usb_ep_pkg::type_of(4'(i / 2));
      assign mps_e[i] = usb_ep_pkg::mps_legal(T, ep_mps[i*usb_ep_pkg::LEN_W +: 10]);
      assign dbl[i] = (T == usb_ep_pkg::EP_BULK) || (T == usb_ep_pkg::EP_ISO);
      assign is_iso[i] = (T == usb_ep_pkg::EP_ISO);
      assign buf_words[i] = usb_ep_pkg::ALLOC_W'(usb_ep_pkg::DATA_OFS)
        + ((usb_ep_pkg::ALLOC_W'(mps_e[i]) + 15'h0003) >> 2);
      assign ep_base[i+1] = ep_base[i] + (!ep_realized[i] ? 15'h0000
        : (dbl[i] ? (buf_words[i] << 1) : buf_words[i]));
      assign ep_live[i] = ep_realized[i]
        && (ep_base[i+1] <= usb_ep_pkg::ALLOC_W'(usb_ep_pkg::RAM_WORDS));
    end
  endgenerate

  // start word of buffer b of endpoint e; buffer 1 follows buffer 0
  function automatic logic [AW-1:0] buf_addr(input logic [4:0] e, input logic b);
    return AW'(ep_base[e]) + (b ? AW'(buf_words[e]) : '0);
  endfunction

  // ==========================================================================
  // shared state
  logic [1:0] full [NP];
  logic [9:0] blen [NP][2];
  logic [NP-1:0] sie_buf;
  logic [NP-1:0] cpu_buf;

  // serial engine side
  usb_ep_pkg::sie_state_t state;
  logic [4:0] cur_ep;
  logic cur_b;
  logic keep;
  logic [AW-1:0] cur_base;
  logic [usb_ep_pkg::CNT_W-1:0] cnt;
  logic [1:0] bidx;
  logic [31:0] rxw;
  logic [31:0] txw;
  logic a_we;
  logic a_re;
  logic [AW-1:0] a_addr;
  logic [31:0] a_wdata;
  logic [31:0] a_q;
  logic ev_set;
  logic ev_clr;
  logic ev_int;
  logic [4:0] ev_ep;
  logic ev_b;
  logic [9:0] ev_len;

  // token decode
  logic [4:0] tok_pe;
  logic tok_b;
  usb_ep_pkg::ep_type_t tok_t;
  logic [9:0] cur_len;
  logic [usb_ep_pkg::CNT_W-1:0] cnt_inc;

  assign tok_pe = {tok_ep, tok_in};
  assign tok_b = sie_buf[tok_pe];
  assign tok_t = usb_ep_pkg::type_of(tok_ep);
  assign cur_len = blen[cur_ep][cur_b];
  assign cnt_inc = cnt + 11'h001;

  // ==========================================================================
  // serial engine transaction sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= usb_ep_pkg::S_IDLE;
      cur_ep <= '0;
      cur_b <= 1'b0;
      keep <= 1'b0;
      cur_base <= '0;
      cnt <= '0;
      bidx <= '0;
      rxw <= '0;
      txw <= '0;
      a_we <= 1'b0;
      a_re <= 1'b0;
      a_addr <= '0;
      a_wdata <= '0;
      tx_valid <= 1'b0;
      tx_byte <= '0;
      tx_last <= 1'b0;
      tx_zlp <= 1'b0;
      hs_ack <= 1'b0;
      hs_nak <= 1'b0;
      ev_set <= 1'b0;
      ev_clr <= 1'b0;
      ev_int <= 1'b0;
      ev_ep <= '0;
      ev_b <= 1'b0;
      ev_len <= '0;
      sie_buf <= '0;
    end
    else
    begin
      // strobes and events last one cycle
      a_we <= 1'b0;
      a_re <= 1'b0;
      tx_zlp <= 1'b0;
      hs_ack <= 1'b0;
      hs_nak <= 1'b0;
      ev_set <= 1'b0;
      ev_clr <= 1'b0;
      ev_int <= 1'b0;
      unique case (state)
        usb_ep_pkg::S_IDLE:
          // nothing moves without a token; unrealized endpoints stay silent
          if (tok_valid && ep_live[tok_pe])
          begin
            cur_ep <= tok_pe;
            cur_b <= tok_b;
            cur_base <= buf_addr(tok_pe, tok_b);
            ev_ep <= tok_pe;
            ev_b <= tok_b;
            cnt <= '0;
            bidx <= '0;
            if (!tok_in)
            begin
              keep <= is_iso[tok_pe] || !full[tok_pe][tok_b];
              state <= usb_ep_pkg::S_RX;
            end
            else if (full[tok_pe][tok_b] && blen[tok_pe][tok_b] != 10'h000)
            begin
              a_addr <= buf_addr(tok_pe, tok_b) + AW'(usb_ep_pkg::DATA_OFS);
              a_re <= 1'b1;
              state <= usb_ep_pkg::S_TX_FETCH;
            end
            else if (full[tok_pe][tok_b])
            begin
              tx_zlp <= 1'b1;
              if (is_iso[tok_pe])
              begin
                ev_clr <= 1'b1;
                sie_buf[tok_pe] <= dbl[tok_pe] ? !tok_b : 1'b0;
              end
              else
                state <= usb_ep_pkg::S_TX_ACK;
            end
            else if (is_iso[tok_pe])
              tx_zlp <= 1'b1;
            else
            begin
              hs_nak <= 1'b1;
              ev_int <= nak_int_in_en[tok_t];
            end
          end
        usb_ep_pkg::S_RX:
        begin
          if (rx_byte_valid)
          begin
            cnt <= cnt_inc;
            if (keep && cnt < usb_ep_pkg::CNT_W'(mps_e[cur_ep]))
            begin
              rxw[bidx*8 +: 8] <= rx_byte;
              bidx <= bidx + 2'b01;
              if (bidx == 2'b11)
              begin
                a_we <= 1'b1;
                a_addr <= cur_base + AW'(usb_ep_pkg::DATA_OFS) + AW'(cnt >> 2);
                a_wdata <= {rx_byte, rxw[23:0]};
              end
            end
          end
          else if (rx_pkt_end)
          begin
            if (keep && !rx_pkt_err && cnt <= usb_ep_pkg::CNT_W'(mps_e[cur_ep]))
            begin
              // flush a part-filled word before the header goes in
              if (bidx != 2'b00)
              begin
                a_we <= 1'b1;
                a_addr <= cur_base + AW'(usb_ep_pkg::DATA_OFS) + AW'(cnt >> 2);
                a_wdata <= rxw;
              end
              state <= usb_ep_pkg::S_RX_HDR;
            end
            else
            begin
              // a bad packet is dropped silently so the host retries it
              if (!keep && !rx_pkt_err)
              begin
                hs_nak <= 1'b1;
                ev_int <= nak_int_out_en[usb_ep_pkg::type_of(cur_ep[4:1])];
              end
              state <= usb_ep_pkg::S_IDLE;
            end
          end
        end
        usb_ep_pkg::S_RX_HDR:
        begin
          a_we <= 1'b1;
          a_addr <= cur_base + AW'(usb_ep_pkg::HDR_OFS);
          a_wdata <= {22'h00_0000, cnt[9:0]};
          ev_len <= cnt[9:0];
          ev_set <= 1'b1;
          sie_buf[cur_ep] <= dbl[cur_ep] ? !cur_b : 1'b0;
          if (!is_iso[cur_ep])
          begin
            hs_ack <= 1'b1;
            ev_int <= 1'b1;
          end
          state <= usb_ep_pkg::S_IDLE;
        end
        usb_ep_pkg::S_TX_FETCH:
          state <= usb_ep_pkg::S_TX_LOAD;
        usb_ep_pkg::S_TX_LOAD:
        begin
          txw <= a_q;
          tx_byte <= a_q[7:0];
          tx_valid <= 1'b1;
          tx_last <= (cnt_inc == usb_ep_pkg::CNT_W'(cur_len));
          bidx <= '0;
          state <= usb_ep_pkg::S_TX_SEND;
        end
        usb_ep_pkg::S_TX_SEND:
          // a word refetch costs three cycles, well inside one full-speed byte
          if (tx_ready)
          begin
            cnt <= cnt_inc;
            if (cnt_inc == usb_ep_pkg::CNT_W'(cur_len))
            begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              if (is_iso[cur_ep])
              begin
                ev_clr <= 1'b1;
                sie_buf[cur_ep] <= dbl[cur_ep] ? !cur_b : 1'b0;
                state <= usb_ep_pkg::S_IDLE;
              end
              else
                state <= usb_ep_pkg::S_TX_ACK;
            end
            else if (bidx == 2'b11)
            begin
              tx_valid <= 1'b0;
              a_addr <= a_addr + 11'h001;
              a_re <= 1'b1;
              state <= usb_ep_pkg::S_TX_FETCH;
            end
            else
            begin
              tx_byte <= txw[(bidx+2'b01)*8 +: 8];
              bidx <= bidx + 2'b01;
              tx_last <= (cnt + 11'h002 == usb_ep_pkg::CNT_W'(cur_len));
            end
          end
        usb_ep_pkg::S_TX_ACK:
          // no acknowledge before the next token: keep the packet for a retry
          if (tx_ack)
          begin
            ev_clr <= 1'b1;
            ev_int <= 1'b1;
            sie_buf[cur_ep] <= dbl[cur_ep] ? !cur_b : 1'b0;
            state <= usb_ep_pkg::S_IDLE;
          end
          else if (tok_valid)
            state <= usb_ep_pkg::S_IDLE;
        default:
          state <= usb_ep_pkg::S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // processor side: drain OUT buffers, fill IN buffers
  logic cpu_b;
  logic [AW-1:0] cpu_base;
  logic [8:0] rd_widx;
  logic [8:0] wr_widx;
  logic [9:0] wlen;
  logic filling;
  logic [1:0] filled [NP];
  logic [8:0] rd_words;
  logic [8:0] wr_words;
  logic cpu_rel;
  logic cpu_fill_done;
  logic cpu_set;
  logic b_we;
  logic b_re;
  logic [AW-1:0] b_addr;

  assign cpu_b = cpu_buf[cpu_ep];
  // written out so the net follows allocation changes, not only cpu_ep
  assign cpu_base = AW'(ep_base[cpu_ep]) + (cpu_b ? AW'(buf_words[cpu_ep]) : '0);
  // a 1023-byte packet needs 256 words, so counts are nine bits wide
  assign rd_words = 9'((11'(blen[cpu_ep][cpu_b]) + 11'h003) >> 2);
  assign wr_words = 9'((11'(wlen) + 11'h003) >> 2);

  // buffer handed back once its last word is read, or at once when empty
  assign cpu_rel = full[cpu_ep][cpu_b] && !cpu_ep[0]
    && ((rx_len_rd && rd_words == 9'h000)
    || (rx_data_rd && rd_widx + 9'h001 >= rd_words));
  assign cpu_fill_done = cpu_ep[0] && ((tx_len_wr && !full[cpu_ep][cpu_b] && tx_len == 10'h000)
    || (tx_data_wr && filling && wr_widx + 9'h001 == wr_words));
  // isochronous buffers wait for explicit validation before the engine sees them
  assign cpu_set = is_iso[cpu_ep] ? (tx_iso_validate && filled[cpu_ep][cpu_b]
    && !full[cpu_ep][cpu_b]) : cpu_fill_done;

  // memory port b follows the strobes directly; read data appears next cycle
  assign b_re = rx_len_rd || rx_data_rd;
  assign b_we = tx_data_wr && filling;
  assign b_addr = rx_len_rd ? cpu_base + AW'(usb_ep_pkg::HDR_OFS)
    : cpu_base + AW'(usb_ep_pkg::DATA_OFS) + AW'(b_we ? wr_widx : rd_widx);

  // processor pointers and the processor-side buffer toggle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_widx <= '0;
      wr_widx <= '0;
      wlen <= '0;
      filling <= 1'b0;
      cpu_buf <= '0;
      for (int i = 0; i < NP; i++)
        filled[i] <= 2'b00;
    end
    else
    begin
      if (rx_len_rd)
        rd_widx <= '0;
      else if (rx_data_rd)
        rd_widx <= rd_widx + 9'h001;
      if (tx_len_wr && !full[cpu_ep][cpu_b])
      begin
        wlen <= tx_len;
        wr_widx <= '0;
        filling <= (tx_len != 10'h000);
      end
      else if (b_we)
      begin
        wr_widx <= wr_widx + 9'h001;
        if (cpu_fill_done)
          filling <= 1'b0;
      end
      if (cpu_fill_done)
        filled[cpu_ep][cpu_b] <= 1'b1;
      else if (cpu_set)
        filled[cpu_ep][cpu_b] <= 1'b0;
      if (cpu_rel || cpu_set)
        cpu_buf[cpu_ep] <= dbl[cpu_ep] ? !cpu_b : 1'b0;
    end
  end

  // ==========================================================================
  // buffer occupancy and lengths; a set in the same cycle beats a clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NP; i++)
        full[i] <= 2'b00;
    end
    else
    begin
      if (ev_clr)
        full[ev_ep][ev_b] <= 1'b0;
      if (cpu_rel)
        full[cpu_ep][cpu_b] <= 1'b0;
      if (ev_set)
        full[ev_ep][ev_b] <= 1'b1;
      if (cpu_set)
        full[cpu_ep][cpu_b] <= 1'b1;
    end
  end

  // lengths copy the OUT header words and the IN fill lengths, so the engine needs no extra read
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NP; i++)
        blen[i] <= '{10'h000, 10'h000};
    end
    else
    begin
      if (ev_set)
        blen[ev_ep][ev_b] <= ev_len;
      // a zero-length fill completes on the length write itself, before wlen loads
      if (cpu_fill_done)
        blen[cpu_ep][cpu_b] <= tx_len_wr ? tx_len : wlen;
    end
  end

  // ==========================================================================
  // interrupts, frame tick and status
  logic [FW-1:0] frame_cnt;

  // pending bits are sticky; a raise while pending is absorbed
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ep_int <= '0;
    else
      ep_int <= (ep_int & ~ep_int_clr) | (ev_int ? (NP'(1) << ev_ep) : '0);
  end

  // free-running frame tick, one pulse every FRAME_CYCLES cycles; nothing inside the block uses it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      frame_cnt <= '0;
      frame_int <= 1'b0;
    end
    else
    begin
      frame_int <= (frame_cnt == FW'(FRAME_CYCLES - 1));
      frame_cnt <= (frame_cnt == FW'(FRAME_CYCLES - 1)) ? '0 : frame_cnt + FW'(1);
    end
  end

  // status copies for software
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      buf_full <= '0;
      alloc_err <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NP; i++)
        buf_full[2*i +: 2] <= full[i];
      alloc_err <= (ep_base[NP] > usb_ep_pkg::ALLOC_W'(usb_ep_pkg::RAM_WORDS));
    end
  end

  usb_ep_ram u_ram
  (
    .clk_sys(clk_sys),
    .a_we(a_we),
    .a_re(a_re),
    .a_addr(a_addr),
    .a_wdata(a_wdata),
    .a_q(a_q),
    .b_we(b_we),
    .b_re(b_re),
    .b_addr(b_addr),
    .b_wdata(tx_data),
    .b_q(cpu_rdata)
  );

endmodule

// ---- verification/usb_ep_checker.sv ----
`timescale 1ns/1ps

// ==========
// port checker for the endpoint data-flow block
module usb_ep_checker
#(
  parameter int FRAME_CYCLES = 50
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // engine inputs
  input wire logic tok_valid,
  input wire logic tok_in,
  input wire logic rx_pkt_end,
  input wire logic rx_pkt_err,
  input wire logic tx_ready,
  // engine outputs
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  input wire logic tx_zlp,
  input wire logic hs_ack,
  input wire logic hs_nak,
  // events
  input wire logic [31:0] ep_int_clr,
  input wire logic [31:0] ep_int,
  input wire logic frame_int
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  int gap;
  logic seen;

  // cycles since the last frame tick; the first tick is skipped since its origin is reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      gap <= 0;
    else
      gap <= frame_int ? 1 : gap + 1;
  end

  // only periods between two ticks are judged
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      seen <= 1'b0;
    else if (frame_int)
      seen <= 1'b1;
  end

  frame_period_a: assert property (seen |-> frame_int == (gap == FRAME_CYCLES))
    else $error("frame tick off period");
  ack_cause_a: assert property (hs_ack |-> $past(rx_pkt_end, 2) && !$past(rx_pkt_err, 2))
    else $error("ack without good packet");
  nak_cause_a: assert property (hs_nak |-> $past(tok_valid && tok_in) || $past(rx_pkt_end))
    else $error("nak without cause");
  hs_excl_a: assert property (!(hs_ack && hs_nak))
    else $error("ack and nak together");
  zlp_cause_a: assert property (tx_zlp |-> $past(tok_valid && tok_in))
    else $error("empty packet without in token");
  tx_start_a: assert property ($rose(tx_valid) |-> $past(tok_valid && tok_in, 3) || $past(tx_valid, 3))
    else $error("data sent unasked");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_last))
    else $error("byte dropped before taken");
  int_sticky_a: assert property (&(~$past(ep_int) | $past(ep_int_clr) | ep_int))
    else $error("pending interrupt lost");
  iso_quiet_a: assert property ((ep_int & 32'h030C_30C0) == 32'h0000_0000)
    else $error("isochronous endpoint interrupt");

  cover property (hs_ack);
  cover property (tx_valid && tx_ready && tx_last);
  cover property (tx_zlp);
endmodule

bind usb_fs_endpoint_dataflow usb_ep_checker #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (.clk_sys,
  .rst_n, .tok_valid, .tok_in, .rx_pkt_end, .rx_pkt_err, .tx_ready, .tx_valid, .tx_byte,
  .tx_last, .tx_zlp, .hs_ack, .hs_nak, .ep_int_clr, .ep_int, .frame_int);

// ---- verification/usb_fs_endpoint_dataflow_test.sv ----
`timescale 1ns/1ps

// ==========
// bench for the endpoint data-flow block
module usb_fs_endpoint_dataflow_test;
  logic clk_sys, rst_n, tok_valid, tok_in, rx_byte_valid, rx_pkt_end, rx_pkt_err, slow, ack_en;
  logic tx_ready, tx_ack, tx_valid, tx_last, tx_zlp, hs_ack, hs_nak, frame_int, alloc_err;
  logic rx_len_rd, rx_data_rd, tx_len_wr, tx_data_wr, tx_iso_validate, sa, sn, sz;
  logic [2:0] nak_int_out_en, nak_int_in_en;
  logic [3:0] tok_ep;
  logic [4:0] cpu_ep;
  logic [7:0] rx_byte, tx_byte;
  logic [9:0] tx_len;
  logic [31:0] cpu_rdata, tx_data, ep_int_clr, ep_int, ep_realized, n, w0, w1;
  logic [63:0] buf_full;
  logic [319:0] ep_mps;
  int fail_count, total_checks, base;

  usb_fs_endpoint_dataflow #(.FRAME_CYCLES(50)) u_dut (.clk_sys, .rst_n, .ep_realized, .ep_mps,
    .nak_int_out_en, .nak_int_in_en, .tok_valid, .tok_in, .tok_ep, .rx_byte_valid, .rx_byte,
    .rx_pkt_end, .rx_pkt_err, .tx_ready, .tx_ack, .tx_valid, .tx_byte, .tx_last, .tx_zlp,
    .hs_ack, .hs_nak, .cpu_ep, .rx_len_rd, .rx_data_rd, .cpu_rdata, .tx_len_wr, .tx_len,
    .tx_data_wr, .tx_data, .tx_iso_validate, .ep_int_clr, .ep_int, .frame_int, .buf_full,
    .alloc_err);
  usb_host_model u_host (.clk_sys, .rst_n, .slow, .ack_en, .tx_valid, .tx_byte, .tx_last,
    .tx_ready, .tx_ack);

  // ==========
  // shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize;
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // run cycles, gathering the one-cycle handshake pulses seen meanwhile
  task run(input int c);
    {sa, sn, sz} = 3'b000;
    repeat (c)
    begin
      #1;
      {sa, sn, sz} = {sa | hs_ack, sn | hs_nak, sz | tx_zlp};
      @(posedge clk_sys);
    end
  endtask
  task token(input logic dir, input logic [3:0] ep);
    @(posedge clk_sys);
    {tok_valid, tok_in, tok_ep} <= {1'b1, dir, ep};
    @(posedge clk_sys);
    tok_valid <= 1'b0;
  endtask
  // bytes 10, 11, ... after an out token, then the end marker in a later cycle
  task out_pkt(input int c);
    token(1'b0, 4'h2);
    for (int k = 0; k < c; k++)
    begin
      {rx_byte_valid, rx_byte} <= {1'b1, 8'h10 + 8'(k)};
      @(posedge clk_sys);
    end
    {rx_byte_valid, rx_pkt_end} <= 2'b01;
    @(posedge clk_sys);
    rx_pkt_end <= 1'b0;
    run(6);
  endtask
  task rd(input logic hdr, output logic [31:0] v);
    @(posedge clk_sys);
    {rx_len_rd, rx_data_rd} <= {hdr, !hdr};
    @(posedge clk_sys);
    {rx_len_rd, rx_data_rd} <= 2'b00;
    @(posedge clk_sys);
    #1 v = cpu_rdata;
  endtask
  task drain;
    rd(1'b1, n);
    rd(1'b0, w0);
    rd(1'b0, w1);
  endtask
  task fill(input logic [9:0] c);
    @(posedge clk_sys);
    {tx_len_wr, tx_len} <= {1'b1, c};
    for (int j = 0; j < (c + 3) / 4; j++)
    begin
      @(posedge clk_sys);
      {tx_len_wr, tx_data_wr, tx_data} <= {2'b01, 32'h2322_2120 + 32'h0404_0404 * j};
    end
    @(posedge clk_sys);
    {tx_len_wr, tx_data_wr} <= 2'b00;
  endtask
  task clr(input int b);
    @(posedge clk_sys);
    ep_int_clr[b] <= 1'b1;
    @(posedge clk_sys);
    ep_int_clr <= 32'h0000_0000;
  endtask
  task set_mps(input logic [31:0] m);
    @(posedge clk_sys);
    for (int i = 0; i < 32; i++)
      ep_mps[10*i+:10] <= m[i] ? 10'h3FF : 10'h040;
    run(3);
  endtask

  // ==========
  // scenarios
  task t_cfg;
    set_mps(32'h030C_30C0);
    chk(alloc_err, 1'b1);
    set_mps(32'h0C30_C30C);
    chk(alloc_err, 1'b0);
    set_mps(32'h0000_0000);
  endtask
  // two packets fill both bulk buffers, a third finds none
  task t_out;
    cpu_ep <= 5'h04;
    out_pkt(6);
    chk(sa, 1'b1);
    out_pkt(6);
    chk(sa, 1'b1);
    clr(4);
    out_pkt(1);
    chk({sa, sn, ep_int[4]}, 3'b010);
    nak_int_out_en <= 3'b100;
    out_pkt(1);
    chk({sn, ep_int[4]}, 2'b11);
    clr(4);
    drain;
    chk(n, 6);
    chk(w0, 32'h1312_1110);
    chk(w1[15:0], 16'h1514);
    drain;
    chk(n, 6);
    chk(buf_full[9:8], 2'b00);
  endtask
  task t_in_empty;
    token(1'b1, 4'h1);
    run(3);
    chk({sn, ep_int[3]}, 2'b10);
    nak_int_in_en <= 3'b010;
    token(1'b1, 4'h1);
    run(3);
    chk({sn, ep_int[3]}, 2'b11);
    clr(3);
  endtask
  task t_in_data;
    {slow, ack_en, cpu_ep} <= {2'b11, 5'h05};
    fill(5);
    base = u_host.got_n;
    token(1'b1, 4'h2);
    run(40);
    chk(u_host.got_n - base, 5);
    for (int k = 0; k < 5; k++)
      chk(u_host.got[base+k], 8'h20 + 8'(k));
    chk(ep_int[5], 1'b1);
  endtask
  task t_iso_in;
    {slow, ack_en, cpu_ep} <= {2'b00, 5'h07};
    fill(3);
    token(1'b1, 4'h3);
    run(4);
    chk(sz, 1'b1);
    @(posedge clk_sys);
    tx_iso_validate <= 1'b1;
    @(posedge clk_sys);
    tx_iso_validate <= 1'b0;
    base = u_host.got_n;
    token(1'b1, 4'h3);
    run(12);
    chk({sz, u_host.got[base+2]}, 9'h022);
    chk(ep_int[7], 1'b0);
  endtask
  task t_frame;
    repeat (60) if (!frame_int) run(1);
    run(1);
    base = 1;
    while (!frame_int && base < 60)
    begin
      run(1);
      base++;
    end
    chk(base, 50);
  endtask

  // ==========
  // clock, reset, stimulus and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = !clk_sys;
  end
  initial
  begin
    {rst_n, tok_valid, tok_in, tok_ep, rx_byte_valid, rx_byte, rx_pkt_end, rx_pkt_err} = '0;
    {rx_len_rd, rx_data_rd, tx_len_wr, tx_len, tx_data_wr, tx_data, tx_iso_validate} = '0;
    {nak_int_out_en, nak_int_in_en, cpu_ep, ep_int_clr, slow, ack_en} = '0;
    {fail_count, total_checks} = '0;
    ep_realized = 32'hFFFF_FFFF;
    ep_mps = {32{10'h040}};
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_cfg;
    t_out;
    t_in_empty;
    t_in_data;
    t_iso_in;
    t_frame;
    summarize;
  end
  // the whole run needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    summarize;
  end
endmodule

// ---- verification/usb_host_model.sv ----
`timescale 1ns/1ps

// ==========
// host side of the transmit stream: takes bytes and acknowledges packets
module usb_host_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // behaviour set by the bench
  input wire logic slow,
  input wire logic ack_en,
  // stream from the device
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tx_ack
);
  logic [7:0] got [0:63];
  int got_n;

  // a slow host takes a byte only every other cycle, to stress the hold of the offer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_ready <= 1'b0;
      tx_ack <= 1'b0;
      got_n <= 0;
    end
    else
    begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      tx_ack <= tx_valid && tx_ready && tx_last && ack_en;
      if (tx_valid && tx_ready)
        got[got_n[5:0]] <= tx_byte;
      got_n <= got_n + int'(tx_valid && tx_ready);
    end
  end
endmodule
